// File: design/cpw_top.v
// complementary pwm generator: duty buffer transfer and forced cutoff
// assumes duty writes and control come from logic on core_clk_i, and the
// comparator outputs arrive asynchronously from the analog side
`timescale 1ns/100ps
`default_nettype none
`include "cpw_defs.vh"

// How it works
// RL1 - interrupt pulse on each carrier-top match
// RL2 - software reloads duty every tenth match
// RL3 - ordinary duty copies at secondary underflow
// RL4 - zero duty: no copy at underflow
// RL5 - zero duty: copy at carrier-top match
// RL6 - zero to nonzero: skip first underflow
// RL7 - zero to nonzero: copy at top match
// RL8 - duty at/above top copies at underflow
// RL9 - above-top to ordinary copies at underflow
// RL10 - two cutoff modes: auto or two-stage
// RL11 - auto mode: rising edge forces hi-z
// RL12 - auto mode: release at next carrier boundary
// RL13 - two-stage: comparator 0 alone auto-releases
// RL14 - two-stage latched: falling edges don't release
// RL15 - software writes release after comparators idle
// RL16 - latched release waits for carrier boundary
// RL17 - period is twice (top plus 2 minus preset)
// RL18 - dead time equals primary preset
// RL19 - software selects mode before starting counters
// RL20 - release resumes current waveform, counters untouched
module cpw_top #(
   parameter WIDTH = `CPW_WIDTH
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // control levels and strobes
   input wire count_start_i,
   input wire overcurrent_detect_mode_bit_i,
   input wire cutoff_release_bit_i,
   // timer setup
   input wire [WIDTH-1:0] carrier_top_compare_i,
   input wire [WIDTH-1:0] primary_preset_i,
   // duty buffer write port
   input wire duty_wr_i,
   input wire [WIDTH-1:0] duty_data_i,
   // comparator pins
   input wire comp0_i,
   input wire comp1_i,
   // power stage pins
   output reg normal_phase_out_o,
   output reg normal_phase_oe_o,
   output reg counter_phase_out_o,
   output reg counter_phase_oe_o,
   // status
   output reg top_match_irq_o,
   output reg [WIDTH-1:0] duty_compare_o,
   output reg hiz_o,
   output reg cutoff_latched_o
);

   // true when the counter sits above duty plus preset (widened sum)
   function above_sum;
      input [WIDTH-1:0] cnt;
      input [WIDTH-1:0] n;
      input [WIDTH-1:0] p;
      reg [WIDTH:0] sum;
      begin
         sum = {1'b0, n} + {1'b0, p};
         above_sum = ({1'b0, cnt} > sum);
      end
   endfunction

   // true when a duty value is the zero special case
   function is_zero;
      input [WIDTH-1:0] v;
      begin
         is_zero = (v == `CPW_DUTY_ZERO);
      end
   endfunction

   // counter state
   reg [WIDTH-1:0] primary_counter_reg;   // counts preset .. top+1 and back
   reg [WIDTH-1:0] primary_counter_next;
   reg dir_reg;                           // up or down half of the carrier
   reg dir_next;
   reg running_reg;                       // counters enabled last cycle

   // duty buffer and active compare
   reg [WIDTH-1:0] duty_buffer_reg;
   reg [WIDTH-1:0] duty_buffer_next;
   reg [WIDTH-1:0] duty_compare_reg;
   reg [WIDTH-1:0] duty_compare_next;
   reg xfer_at_top_reg;                   // next copy must wait for top match
   reg xfer_at_top_next;

   // cutoff state
   reg hiz_reg;
   reg hiz_next;
   reg latched_reg;                       // two-stage latched cutoff
   reg latched_next;
   reg release_req_reg;                   // software asked for release
   reg release_req_next;

   // waveform decode
   reg normal_active;
   reg counter_active;

   // timing events
   wire [WIDTH:0] top_plus_one;           // turning point of the up count
   wire top_match;                        // primary equals carrier top on the way up
   wire underflow;                        // secondary counter wraps at the trough
   wire carrier_edge;                     // carrier-period boundary

   // synchronised comparator view
   wire [`CPW_NCMP-1:0] cmp_level;
   wire [`CPW_NCMP-1:0] cmp_rise;
   wire cmp_idle;                         // both comparators inactive
   wire mode_auto;

   // comparator pins are asynchronous, so each passes two flops
   cpw_pin_sync #(
      .WIDTH(`CPW_NCMP)
   ) u_cmp_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i({comp1_i, comp0_i}),
      .level_o(cmp_level),
      .rise_o(cmp_rise),
      .fall_o()
   );

   assign top_plus_one = {1'b0, carrier_top_compare_i} + {{WIDTH{1'b0}}, 1'b1};
   // RL1 carrier-top match
   assign top_match = running_reg && (dir_reg == `CPW_DIR_UP) &&
                      (primary_counter_reg == carrier_top_compare_i);
   // the secondary counter is the primary minus preset, so it wraps here
   assign underflow = running_reg && (dir_reg == `CPW_DIR_DOWN) &&
                      (primary_counter_reg == primary_preset_i);
   assign carrier_edge = underflow;
   assign cmp_idle = ~cmp_level[`CPW_CMP0] & ~cmp_level[`CPW_CMP1];
   // RL19 mode bit is expected stable once counting
   assign mode_auto = (overcurrent_detect_mode_bit_i == `CPW_MODE_AUTO);

   // carrier counter: up and down halves each hold the turn value once
   always @* begin
      primary_counter_next = primary_counter_reg;
      dir_next = dir_reg;
      if (!count_start_i) begin
         // stopped: park at the preset so a start gives a full period
         primary_counter_next = primary_preset_i;
         dir_next = `CPW_DIR_UP;
      end else if (!running_reg) begin
         primary_counter_next = primary_preset_i;
         dir_next = `CPW_DIR_UP;
      end else if (dir_reg == `CPW_DIR_UP) begin
         // RL17 up half spans top+2-preset cycles
         if ({1'b0, primary_counter_reg} == top_plus_one) begin
            dir_next = `CPW_DIR_DOWN;
         end else begin
            primary_counter_next = primary_counter_reg + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end else begin
         // RL17 down half mirrors the up half
         if (primary_counter_reg == primary_preset_i) begin
            dir_next = `CPW_DIR_UP;
         end else begin
            primary_counter_next = primary_counter_reg - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // duty buffer, transfer timing and its special cases
   always @* begin
      duty_buffer_next = duty_buffer_reg;
      duty_compare_next = duty_compare_reg;
      xfer_at_top_next = xfer_at_top_reg;
      // transfers happen first, so a write in the same cycle is never lost
      if (xfer_at_top_reg) begin
         // RL5 zero copies at top match
         // RL7 first top match after zero exit
         if (top_match) begin
            duty_compare_next = duty_buffer_reg;
            xfer_at_top_next = 1'b0;
         end
         // RL4 no copy at underflow here
         // RL6 first underflow is skipped
      end else if (underflow) begin
         // RL3 ordinary copy at underflow
         // RL8 values at or above top copy here too
         // RL9 leaving above-top copies at first underflow
         duty_compare_next = duty_buffer_reg;
      end
      // RL2 software write; entering or leaving zero defers to top match
      if (duty_wr_i) begin
         duty_buffer_next = duty_data_i;
         if (is_zero(duty_data_i) || is_zero(duty_buffer_reg)) begin
            xfer_at_top_next = 1'b1;
         end
      end
   end

   // waveform decode from the active compare only
   always @* begin
      normal_active = 1'b0;
      counter_active = 1'b0;
      if (!running_reg) begin
         // idle counters leave both phases inactive
         normal_active = 1'b0;
         counter_active = 1'b0;
      end else if (is_zero(duty_compare_reg)) begin
         // zero compare: normal phase constantly active
         normal_active = 1'b1;
         counter_active = 1'b0;
      end else begin
         // RL18 the preset gap between the two thresholds is the dead time
         normal_active = above_sum(primary_counter_reg, duty_compare_reg,
                                   primary_preset_i);
         // above top the counter phase stays active throughout
         counter_active = (primary_counter_reg <= duty_compare_reg);
      end
   end

   // cutoff control for both detection modes
   always @* begin
      hiz_next = hiz_reg;
      latched_next = latched_reg;
      release_req_next = release_req_reg;
      // RL10 mode select
      if (mode_auto) begin
         // auto mode never latches
         latched_next = 1'b0;
         release_req_next = 1'b0;
         // RL12 release only at boundary once the trigger fell
         if (hiz_reg && carrier_edge && cmp_idle) begin
            hiz_next = 1'b0;
         end
         // RL11 any rising edge cuts off; set wins over release
         if (cmp_rise[`CPW_CMP0] || cmp_rise[`CPW_CMP1]) begin
            hiz_next = 1'b1;
         end
      end else begin
         // RL15 software strobe is only honoured while latched
         if (cutoff_release_bit_i && latched_reg) begin
            release_req_next = 1'b1;
         end
         if (latched_reg) begin
            // RL14 falling edges do nothing while latched
            // RL16 release at carrier boundary after the strobe
            if ((release_req_reg || cutoff_release_bit_i) && carrier_edge && cmp_idle) begin
               hiz_next = 1'b0;
               latched_next = 1'b0;
               release_req_next = 1'b0;
            end
         end else if (hiz_reg && carrier_edge && cmp_idle) begin
            // RL13 comparator 0 alone releases automatically
            hiz_next = 1'b0;
         end
         // second stage or repeated trip latches; set wins over release
         if (cmp_rise[`CPW_CMP1] || (cmp_rise[`CPW_CMP0] && hiz_reg)) begin
            hiz_next = 1'b1;
            latched_next = 1'b1;
            release_req_next = 1'b0;
         end else if (cmp_rise[`CPW_CMP0]) begin
            hiz_next = 1'b1;
         end
      end
   end

   // state registers
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         primary_counter_reg <= {WIDTH{1'b0}};
         dir_reg <= `CPW_DIR_UP;
         running_reg <= 1'b0;
         duty_buffer_reg <= `CPW_DUTY_RST;
         duty_compare_reg <= `CPW_DUTY_RST;
         xfer_at_top_reg <= 1'b0;
         hiz_reg <= 1'b0;
         latched_reg <= 1'b0;
         release_req_reg <= 1'b0;
      end else begin
         primary_counter_reg <= primary_counter_next;
         dir_reg <= dir_next;
         running_reg <= count_start_i;
         duty_buffer_reg <= duty_buffer_next;
         duty_compare_reg <= duty_compare_next;
         xfer_at_top_reg <= xfer_at_top_next;
         hiz_reg <= hiz_next;
         latched_reg <= latched_next;
         release_req_reg <= release_req_next;
      end
   end

   // output flops; enables follow the next cutoff state so a trip is prompt
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         normal_phase_out_o <= `CPW_LVL_INACTIVE;
         counter_phase_out_o <= `CPW_LVL_INACTIVE;
         normal_phase_oe_o <= 1'b1;
         counter_phase_oe_o <= 1'b1;
         top_match_irq_o <= 1'b0;
         duty_compare_o <= `CPW_DUTY_RST;
         hiz_o <= 1'b0;
         cutoff_latched_o <= 1'b0;
      end else begin
         // RL20 levels keep tracking the live waveform during hi-z
         normal_phase_out_o <= normal_active ? `CPW_LVL_ACTIVE : `CPW_LVL_INACTIVE;
         counter_phase_out_o <= counter_active ? `CPW_LVL_ACTIVE : `CPW_LVL_INACTIVE;
         // RL11 both pins float together
         normal_phase_oe_o <= ~hiz_next;
         counter_phase_oe_o <= ~hiz_next;
         // RL1 one-cycle request per match
         top_match_irq_o <= top_match;
         duty_compare_o <= duty_compare_next;
         hiz_o <= hiz_next;
         cutoff_latched_o <= latched_next;
      end
   end

endmodule

`default_nettype wire

// File: design/cpw_defs.vh
// constants for the complementary pwm transfer and cutoff block
// assumes a single 20 MHz core clock and a synchronous active-low reset
`ifndef CPW_DEFS_VH
`define CPW_DEFS_VH

// default counter and compare width
`define CPW_WIDTH 16
// reset value of the duty buffer and the active duty compare
`define CPW_DUTY_RST 16'h0000
// duty value that asks for the constant active-level waveform
`define CPW_DUTY_ZERO 16'h0000
// overcurrent detect mode bit encodings
`define CPW_MODE_AUTO 1'b1
`define CPW_MODE_TWO_STAGE 1'b0
// counter direction encodings
`define CPW_DIR_UP 1'b0
`define CPW_DIR_DOWN 1'b1
// pin levels: both phases are active low
`define CPW_LVL_ACTIVE 1'b0
`define CPW_LVL_INACTIVE 1'b1
// index of each comparator in the synchronised vector
`define CPW_CMP0 0
`define CPW_CMP1 1
// number of comparator inputs
`define CPW_NCMP 2

`endif

// File: design/cpw_pin_sync.v
// two-flop synchroniser with edge detection for asynchronous pins
// assumes the pins are slow levels from analog comparators
`timescale 1ns/100ps
`default_nettype none

module cpw_pin_sync #(
   parameter WIDTH = 2
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // raw pins
   input wire [WIDTH-1:0] pin_i,
   // synchronised level and one-cycle edge pulses
   output wire [WIDTH-1:0] level_o,
   output wire [WIDTH-1:0] rise_o,
   output wire [WIDTH-1:0] fall_o
);

   // first stage: read only by the second stage
   reg [WIDTH-1:0] meta_reg;
   // second stage: first safe copy
   reg [WIDTH-1:0] sync_reg;
   // previous safe copy for edge detection
   reg [WIDTH-1:0] prev_reg;

   // capture chain; edges come from the two safe stages only
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
         prev_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o = sync_reg & ~prev_reg;
   assign fall_o = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

// File: sim/cpw_chk.sv
// assertions on the pins of the complementary pwm block
// assumes binding to cpw_top, one clock, counters started after a match
`timescale 1ns/100ps
`default_nettype none
module cpw_chk #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // inputs
   input wire logic count_start_i,
   input wire logic overcurrent_detect_mode_bit_i,
   input wire logic comp1_i,
   input wire logic [WIDTH-1:0] carrier_top_compare_i,
   input wire logic [WIDTH-1:0] primary_preset_i,
   // outputs
   input wire logic normal_phase_oe_o,
   input wire logic counter_phase_oe_o,
   input wire logic top_match_irq_o,
   input wire logic [WIDTH-1:0] duty_compare_o,
   input wire logic hiz_o,
   input wire logic cutoff_latched_o
);
   // cycles since the last match pulse, zero until one is seen
   int gap_reg;
   // full period and the trough position after a match
   int per;
   int half;
   assign per = 2 * (int'(carrier_top_compare_i) + 2 - int'(primary_preset_i));
   assign half = per / 2 + 1;
   // gap counter restarts with the counters, so a fresh start is not judged
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !count_start_i) gap_reg <= 0;
      else if (top_match_irq_o) gap_reg <= 1;
      else if (gap_reg != 0) gap_reg <= gap_reg + 1;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_irq_one_cycle: assert property (top_match_irq_o |=> !top_match_irq_o)
      else $error("match pulse longer than one cycle");
   a_irq_period: assert property (top_match_irq_o && gap_reg != 0 |-> gap_reg == per)
      else $error("match pulses not one period apart");
   a_oe_pair: assert property (normal_phase_oe_o == counter_phase_oe_o && hiz_o == !normal_phase_oe_o)
      else $error("phase enables disagree");
   a_trip_to_hiz: assert property ($rose(comp1_i) |-> ##[1:5] hiz_o)
      else $error("no float after comparator rise");
   a_release_trough: assert property ($fell(hiz_o) |-> gap_reg == half)
      else $error("float released off the carrier boundary");
   // copy only at trough or match
   a_copy_moment: assert property ($changed(duty_compare_o) |-> top_match_irq_o || gap_reg == half)
      else $error("duty compare changed at a wrong moment");
   a_latch_keeps_hiz: assert property (cutoff_latched_o |-> hiz_o)
      else $error("latched cutoff without float");
   a_latch_release: assert property ($fell(cutoff_latched_o) && !overcurrent_detect_mode_bit_i |-> $fell(hiz_o))
      else $error("latch cleared without release of float");
   a_latch_mode: assert property ($rose(cutoff_latched_o) |-> !overcurrent_detect_mode_bit_i)
      else $error("latch set in auto release mode");
endmodule
bind cpw_top cpw_chk #(.WIDTH(WIDTH)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .count_start_i(count_start_i), .overcurrent_detect_mode_bit_i(overcurrent_detect_mode_bit_i),
   .comp1_i(comp1_i), .carrier_top_compare_i(carrier_top_compare_i),
   .primary_preset_i(primary_preset_i), .normal_phase_oe_o(normal_phase_oe_o),
   .counter_phase_oe_o(counter_phase_oe_o), .top_match_irq_o(top_match_irq_o),
   .duty_compare_o(duty_compare_o), .hiz_o(hiz_o), .cutoff_latched_o(cutoff_latched_o));
`default_nettype wire

// File: sim/cpw_pwr_model.sv
// comparators and power stage seen from the pwm pins
// assumes trip requests from the bench; comparator edges arrive unaligned
`timescale 1ns/100ps
`default_nettype none
module cpw_pwr_model (
   // clock
   input wire logic core_clk_i,
   // trip requests
   input wire logic trip0_i,
   input wire logic trip1_i,
   // pwm pins
   input wire logic normal_phase_out_i,
   input wire logic normal_phase_oe_i,
   input wire logic counter_phase_out_i,
   input wire logic counter_phase_oe_i,
   // comparator outputs and pin levels
   output logic comp0_o,
   output logic comp1_o,
   output logic normal_pin_o,
   output logic counter_pin_o
);
   // floating level changes every cycle so a stale value never passes
   logic float_reg = 1'b0;
   initial comp0_o = 1'b0;
   initial comp1_o = 1'b0;
   always @(posedge core_clk_i) float_reg <= ~float_reg;
   // comparator outputs lag the request off the clock grid
   always @(trip0_i) comp0_o <= #7 trip0_i;
   always @(trip1_i) comp1_o <= #7 trip1_i;
   assign normal_pin_o = normal_phase_oe_i ? normal_phase_out_i : float_reg;
   assign counter_pin_o = counter_phase_oe_i ? counter_phase_out_i : ~float_reg;
endmodule
`default_nettype wire

// File: sim/complementary_pwm_buffer_cutoff_tb.sv
// self-checking bench for the pwm transfer and cutoff block
// assumes top 20 and preset 4, so one carrier period is 36 cycles
`timescale 1ns/100ps
`default_nettype none
`include "cpw_defs.vh"
module complementary_pwm_buffer_cutoff_tb;
   localparam int PER = 36;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic run = 1'b0;
   logic mode = `CPW_MODE_AUTO;
   logic rel = 1'b0;
   logic wr = 1'b0;
   logic [15:0] data = 16'h0000;
   logic [1:0] trips = 2'b00;
   wire logic comp0, comp1, n_out, n_oe, c_out, c_oe, irq, hiz, latched, n_pin, c_pin;
   wire logic [15:0] duty;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n_match = 0;
   always #25 core_clk_i = ~core_clk_i;
   // match count since start, so reloads keep the tenth-match cadence
   always @(posedge core_clk_i) begin
      if (irq === 1'b1) n_match++;
   end
   cpw_top #(.WIDTH(16)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .count_start_i(run),
      .overcurrent_detect_mode_bit_i(mode), .cutoff_release_bit_i(rel),
      .carrier_top_compare_i(16'h0014), .primary_preset_i(16'h0004), .duty_wr_i(wr),
      .duty_data_i(data), .comp0_i(comp0), .comp1_i(comp1), .normal_phase_out_o(n_out),
      .normal_phase_oe_o(n_oe), .counter_phase_out_o(c_out), .counter_phase_oe_o(c_oe),
      .top_match_irq_o(irq), .duty_compare_o(duty), .hiz_o(hiz), .cutoff_latched_o(latched));
   cpw_pwr_model u_pwr (.core_clk_i(core_clk_i), .trip0_i(trips[0]), .trip1_i(trips[1]),
      .normal_phase_out_i(n_out), .normal_phase_oe_i(n_oe), .counter_phase_out_i(c_out),
      .counter_phase_oe_i(c_oe), .comp0_o(comp0), .comp1_o(comp1), .normal_pin_o(n_pin),
      .counter_pin_o(c_pin));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // inputs move 1 ns after the rising edge
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wait_irq;
      int k;
      cycles(1);
      for (k = 0; k < 2 * PER && irq !== 1'b1; k++) cycles(1);
      check("match pulse", irq, 1'b1);
   endtask
   // a reload just after a match, as controlling software does
   task automatic put(input logic [15:0] v, input int gap);
      // reload only at every tenth match
      do begin
         wait_irq();
      end while ((n_match + 1) % 10 != 0);
      data = v;
      wr = 1'b1;
      cycles(1);
      wr = 1'b0;
      cycles(gap);
   endtask
   // active cycles of each phase over one whole period
   task automatic measure(input int ne, input int ce);
      int n;
      int c;
      int k;
      n = 0;
      c = 0;
      for (k = 0; k < PER; k++) begin
         cycles(1);
         n += (n_pin === `CPW_LVL_ACTIVE);
         c += (c_pin === `CPW_LVL_ACTIVE);
      end
      check("normal active", n[15:0], ne[15:0]);
      check("counter active", c[15:0], ce[15:0]);
   endtask
   task automatic t_transfers;
      put(16'h000c, 24);
      check("zero exit at trough", duty, 16'h0000);
      wait_irq();
      check("zero exit at match", duty, 16'h000c);
      put(16'h0008, 10);
      check("before trough", duty, 16'h000c);
      cycles(14);
      check("ordinary at trough", duty, 16'h0008);
      measure(18, 10);
      put(16'h0019, 24);
      check("full at trough", duty, 16'h0019);
      measure(0, 36);
      put(16'h000a, 24);
      check("back at trough", duty, 16'h000a);
      measure(14, 14);
      $display("transfer test done");
   endtask
   task automatic trip(input int i, input logic lat);
      wait_irq();
      cycles(2);
      trips[i] = 1'b1;
      cycles(6);
      check("float on trip", {13'h0000, n_oe, c_oe, hiz}, 16'h0001);
      check("latch on trip", latched, lat);
      trips[i] = 1'b0;
      cycles(6);
      check("float after fall", hiz, 1'b1);
   endtask
   task automatic t_cutoff;
      int i;
      int k;
      for (i = 0; i < 2; i++) begin
         trip(i, 1'b0);
         cycles(10);
         check("auto release", hiz, 1'b0);
      end
      measure(14, 14);
      run = 1'b0;
      cycles(2);
      mode = `CPW_MODE_TWO_STAGE;
      run = 1'b1;
      trip(0, 1'b0);
      cycles(10);
      check("stage one release", hiz, 1'b0);
      trip(1, 1'b1);
      cycles(80);
      check("latched float held", hiz, 1'b1);
      // release pulse with both comparators low
      rel = 1'b1;
      cycles(1);
      rel = 1'b0;
      for (k = 0; k < 2 * PER && hiz !== 1'b0; k++) cycles(1);
      check("release after pulse", {latched, hiz}, 2'b00);
      measure(14, 14);
      $display("cutoff test done");
   endtask
   task automatic t_zero;
      put(16'h0000, 24);
      check("zero kept at trough", duty, 16'h000a);
      wait_irq();
      check("zero at match", duty, 16'h0000);
      measure(36, 0);
      $display("zero test done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard well above the roughly 2200 cycles the tests need
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("timeout after %0d cycles", cyc);
         finish_test();
      end
   end
   initial begin
      cycles(5);
      rst_n_i = 1'b1;
      cycles(4);
      run = 1'b1;
      t_transfers();
      t_cutoff();
      t_zero();
      finish_test();
   end
endmodule
`default_nettype wire
